/* shared/cmb_pkg.sv */
// cmb_pkg: constants, codes and frame carriers for the message slot block.
// assumes one module clock; the protocol engine sits on the same clock.
package cmb_pkg;

   ////////////////////
   // sizes
   localparam int unsigned SLOTS      = 16;
   localparam int unsigned IDX_W      = 4;
   localparam int unsigned ADDR_W     = 9;

   ////////////////////
   // host address map, byte addresses
   localparam logic [8:0] TIMER_OFS   = 9'h008;  // read also unlocks a slot
   localparam logic [8:0] IRQ_EN_OFS  = 9'h028;
   localparam logic [8:0] FLAG_OFS    = 9'h030;
   localparam logic [8:0] SLOT_BASE   = 9'h080;
   localparam logic [8:0] SLOT_END    = 9'h17F;
   localparam logic [1:0] CS_WORD     = 2'h0;
   localparam logic [1:0] ID_WORD     = 2'h1;
   localparam logic [1:0] DLO_WORD    = 2'h2;    // bytes 0x8..0xB
   localparam logic [1:0] DHI_WORD    = 2'h3;    // bytes 0xC..0xF

   ////////////////////
   // control/status word fields
   localparam int unsigned CODE_LO    = 24;
   localparam int unsigned CODE_HI    = 27;
   localparam int unsigned IDE_POS    = 21;
   localparam int unsigned RTR_POS    = 20;
   localparam int unsigned LEN_LO     = 16;
   localparam int unsigned LEN_HI     = 19;
   localparam int unsigned TS_HI      = 15;
   localparam logic [31:0] CS_MASK    = 32'h0F3F_FFFF;  // reserved bits read zero
   localparam logic [31:0] ID_MASK    = 32'h1FFF_FFFF;
   localparam logic [28:0] STD_MASK   = 29'h1FFC_0000;  // id bits 28..18
   localparam logic [31:0] WORD_RST   = 32'h0000_0000;

   ////////////////////
   // slot codes
   localparam logic [3:0] RX_INACTIVE = 4'h0;
   localparam logic [3:0] RX_EMPTY    = 4'h4;
   localparam logic [3:0] RX_FULL     = 4'h2;
   localparam logic [3:0] RX_OVERRUN  = 4'h6;
   localparam logic [3:0] BUSY_BIT    = 4'h1;
   localparam logic [3:0] TX_INACTIVE = 4'h8;
   localparam logic [3:0] TX_ONCE     = 4'hC;

   ////////////////////
   // receive store sequence
   typedef enum logic [1:0] {
      CMB_IDLE = 2'b00,
      CMB_BUSY = 2'b01,
      CMB_FILL = 2'b11,
      CMB_WAIT = 2'b10
   } cmb_rx_state_t;

   // frame handed in by the protocol engine
   typedef struct packed {
      logic [28:0] id;
      logic        ide;
      logic        rtr;
      logic [3:0]  dlc;
      logic [63:0] data;    // byte 0 in bits 63..56
   } cmb_frame_t;

   // frame handed out to the protocol engine
   typedef struct packed {
      logic [28:0] id;
      logic        ide;
      logic        rtr;
      logic [3:0]  dlc;
      logic [3:0]  data_len; // bytes really sent, zero for remote frames
      logic [63:0] data;
   } cmb_tx_frame_t;

endpackage : cmb_pkg

/* src/cmb_match.sv */
// cmb_match: lowest active receive slot matching a frame, combinational.
// assumes codes and identifiers come straight from slot storage.
module cmb_match #(
   parameter int unsigned SLOTS = cmb_pkg::SLOTS,
   parameter int unsigned IDX_W = cmb_pkg::IDX_W
) (
   input  wire logic [SLOTS-1:0][31:0] cs_words,
   input  wire logic [SLOTS-1:0][31:0] id_words,
   input  wire cmb_pkg::cmb_frame_t    frame,
   output logic                        hit,
   output logic [IDX_W-1:0]            idx
);
   import cmb_pkg::*;

   ////////////////////
   // scan from the top so the lowest slot wins
   always_comb begin
      logic [3:0]  code;
      logic [28:0] cmp_mask;
      code     = RX_INACTIVE;
      cmp_mask = STD_MASK;
      hit      = 1'b0;
      idx      = '0;
      for (int i = SLOTS - 1; i >= 0; i--) begin
         code = cs_words[i][CODE_HI:CODE_LO];
         // standard frames compare only the upper eleven bits
         cmp_mask = frame.ide ? 29'h1FFF_FFFF : STD_MASK;
         if ((code == RX_EMPTY || code == RX_FULL || code == RX_OVERRUN)
             && cs_words[i][IDE_POS] == frame.ide
             && ((id_words[i][28:0] ^ frame.id) & cmp_mask) == 29'h0) begin
            hit = 1'b1;
            idx = IDX_W'(i);
         end
      end
   end

endmodule : cmb_match

/* src/cmb_slots.sv */
// cmb_slots: message slots, receive codes, transmit hand-out, flags.
// assumes the protocol engine and the host share ref_clk.
//
// Function
// - rtr sent recessive, seen dominant: arbitration lost
// - rtr sent dominant, seen recessive: bit error
// - rtr bit zero data frame, one remote
// - received dlc stored in length field 19..16
// - length field sent as outgoing dlc
// - remote frame sent without data bytes
// - data bytes at slot offsets 0x8..0xF
// - timer captured at identifier start
// - standard frames use id bits 28..18
// - extended frames use all 29 id bits
// - received data stored as it arrived
// - inactive receive slot ignored, code kept
// - empty slot becomes full after reception
// - full slot read and unlocked stays full
// - unread full slot overwritten becomes overrun
// - serviced overrun slot refilled becomes full
// - unserviced overrun slot overwritten stays overrun
// - busy pattern during store, then full/overrun
// - code at bits 27..24, shared access
// - format bit 21: standard or extended
// - completion flag, maskable request, write-one clear
//
// Added by the designer: the address-and-strobe port and the placing of the registers.
module cmb_slots #(
   parameter int unsigned SLOTS = cmb_pkg::SLOTS,
   parameter int unsigned IDX_W = cmb_pkg::IDX_W
) (
   input  wire logic                       ref_clk,
   input  wire logic                       rst_n,
   // host register port
   input  wire logic [cmb_pkg::ADDR_W-1:0] host_addr,
   input  wire logic [31:0]                host_wdata,
   input  wire logic                       host_wr,
   input  wire logic                       host_rd,
   output logic [31:0]                     host_rdata,
   // receive side of the protocol engine
   input  wire logic                       rx_valid,
   input  wire cmb_pkg::cmb_frame_t        rx_frame,
   output logic                            rx_ready,
   input  wire logic                       id_start,
   // transmit side of the protocol engine
   input  wire logic                       tx_fetch,
   output logic                            tx_valid,
   output cmb_pkg::cmb_tx_frame_t          tx_frame,
   input  wire logic                       tx_done,
   // remote bit monitor
   input  wire logic                       rtr_check,
   input  wire logic                       rtr_sent,
   input  wire logic                       rtr_seen,
   output logic                            arb_lost,
   output logic                            bit_error,
   // completion request
   output logic                            irq
);
   import cmb_pkg::*;

   ////////////////////
   // helpers

   // true when the address lands in slot space
   function automatic logic in_slots(input logic [ADDR_W-1:0] a);
      in_slots = (a >= SLOT_BASE) && (a <= SLOT_END);
   endfunction : in_slots

   // slot index of a slot space address
   function automatic logic [IDX_W-1:0] slot_of(input logic [ADDR_W-1:0] a);
      logic [ADDR_W-1:0] rel;
      rel     = a - SLOT_BASE;
      slot_of = rel[IDX_W+3:4];
   endfunction : slot_of

   // word within a slot
   function automatic logic [1:0] word_of(input logic [ADDR_W-1:0] a);
      word_of = a[3:2];
   endfunction : word_of

   ////////////////////
   // state
   logic [SLOTS-1:0][31:0] cs_reg;
   logic [SLOTS-1:0][31:0] id_reg;
   logic [SLOTS-1:0][31:0] dlo_reg;
   logic [SLOTS-1:0][31:0] dhi_reg;
   logic [SLOTS-1:0]       flag_reg;
   logic [SLOTS-1:0]       irq_en_reg;
   logic [SLOTS-1:0]       serviced_reg;
   logic [15:0]            timer_reg;
   logic [15:0]            stamp_reg;
   logic                   lock_valid_reg;
   logic [IDX_W-1:0]       lock_idx_reg;
   cmb_rx_state_t          rx_state_reg;
   cmb_rx_state_t          rx_state_next;
   cmb_frame_t             pend_reg;
   logic [IDX_W-1:0]       pend_idx_reg;
   logic [3:0]             prev_code_reg;
   logic [IDX_W-1:0]       tx_idx_reg;
   logic [31:0]            rdata_reg;
   logic                   rx_ready_reg;
   logic                   tx_valid_reg;
   cmb_tx_frame_t          tx_frame_reg;
   logic                   arb_lost_reg;
   logic                   bit_error_reg;
   logic                   irq_reg;

   logic                   match_hit;
   logic [IDX_W-1:0]       match_idx;
   logic                   host_slot_wr;
   logic                   host_cs_rd;
   logic                   unlock;
   logic                   tx_hit;
   logic [IDX_W-1:0]       tx_pick;
   logic [SLOTS-1:0]       flag_set;

   ////////////////////
   // identifier matching for the frame on offer
   cmb_match #(
      .SLOTS (SLOTS),
      .IDX_W (IDX_W)
   ) u_match (
      .cs_words (cs_reg),
      .id_words (id_reg),
      .frame    (rx_frame),
      .hit      (match_hit),
      .idx      (match_idx)
   );

   ////////////////////
   // host access decode
   assign host_slot_wr = host_wr && in_slots(host_addr);
   assign host_cs_rd   = host_rd && in_slots(host_addr) && word_of(host_addr) == CS_WORD;
   assign unlock       = host_rd && host_addr == TIMER_OFS;

   // lowest slot ready to send once
   always_comb begin
      tx_hit  = 1'b0;
      tx_pick = '0;
      for (int i = SLOTS - 1; i >= 0; i--) begin
         if (cs_reg[i][CODE_HI:CODE_LO] == TX_ONCE) begin
            tx_hit  = 1'b1;
            tx_pick = IDX_W'(i);
         end
      end
   end

   ////////////////////
   // free running timer and identifier start capture
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         timer_reg <= '0;
         stamp_reg <= '0;
      end else begin
         timer_reg <= timer_reg + 16'h0001;
         if (id_start) begin
            stamp_reg <= timer_reg;
         end
      end
   end

   ////////////////////
   // lock: one slot at a time, the read of the timer releases it
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         lock_valid_reg <= 1'b0;
         lock_idx_reg   <= '0;
         serviced_reg   <= '0;
      end else begin
         if (host_cs_rd) begin
            lock_valid_reg <= 1'b1;
            lock_idx_reg   <= slot_of(host_addr);
         end else if (unlock) begin
            lock_valid_reg <= 1'b0;
         end
         // a store clears the serviced mark; the unlock in the same cycle wins
         if (rx_state_reg == CMB_FILL) begin
            serviced_reg[pend_idx_reg] <= 1'b0;
         end
         if (unlock && lock_valid_reg) begin
            serviced_reg[lock_idx_reg] <= 1'b1;
         end
      end
   end

   ////////////////////
   // receive store sequence: accept, busy mark, fill
   always_comb begin
      rx_state_next = rx_state_reg;
      case (rx_state_reg)
         CMB_IDLE: begin
            if (rx_valid && rx_ready_reg && match_hit) begin
               // a locked target holds the frame until the host lets go
               if (lock_valid_reg && lock_idx_reg == match_idx) begin
                  rx_state_next = CMB_WAIT;
               end else begin
                  rx_state_next = CMB_BUSY;
               end
            end
         end
         CMB_WAIT: begin
            if (!lock_valid_reg || lock_idx_reg != pend_idx_reg) begin
               rx_state_next = CMB_BUSY;
            end
         end
         CMB_BUSY: rx_state_next = CMB_FILL;
         CMB_FILL: rx_state_next = CMB_IDLE;
         default:  rx_state_next = CMB_IDLE;
      endcase
   end

   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         rx_state_reg  <= CMB_IDLE;
         rx_ready_reg  <= 1'b0;
         pend_reg      <= '0;
         pend_idx_reg  <= '0;
      end else begin
         rx_state_reg <= rx_state_next;
         // ready only while idle: the engine stalls during a store
         rx_ready_reg <= rx_state_next == CMB_IDLE;
         if (rx_state_reg == CMB_IDLE && rx_valid && rx_ready_reg) begin
            pend_reg     <= rx_frame;
            pend_idx_reg <= match_idx;
         end
      end
   end

   ////////////////////
   // slot storage: host writes, receive stores, transmit completion
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         cs_reg        <= '{default: WORD_RST};
         id_reg        <= '{default: WORD_RST};
         dlo_reg       <= '{default: WORD_RST};
         dhi_reg       <= '{default: WORD_RST};
         prev_code_reg <= RX_INACTIVE;
      end else begin
         // host writes; the host stays off busy slots, so no guard here
         if (host_slot_wr) begin
            case (word_of(host_addr))
               CS_WORD:  cs_reg[slot_of(host_addr)]  <= host_wdata & CS_MASK;
               ID_WORD:  id_reg[slot_of(host_addr)]  <= host_wdata & ID_MASK;
               DLO_WORD: dlo_reg[slot_of(host_addr)] <= host_wdata;
               default:  dhi_reg[slot_of(host_addr)] <= host_wdata;
            endcase
         end
         // busy mark: low code bit set while the frame goes in
         if (rx_state_reg == CMB_BUSY) begin
            prev_code_reg <= cs_reg[pend_idx_reg][CODE_HI:CODE_LO];
            cs_reg[pend_idx_reg][CODE_LO] <= 1'b1;
         end
         if (rx_state_reg == CMB_FILL) begin
            if (prev_code_reg == RX_EMPTY || serviced_reg[pend_idx_reg]) begin
               cs_reg[pend_idx_reg][CODE_HI:CODE_LO] <= RX_FULL;
            end else begin
               cs_reg[pend_idx_reg][CODE_HI:CODE_LO] <= RX_OVERRUN;
            end
            cs_reg[pend_idx_reg][IDE_POS]         <= pend_reg.ide;
            cs_reg[pend_idx_reg][RTR_POS]         <= pend_reg.rtr;
            cs_reg[pend_idx_reg][LEN_HI:LEN_LO]   <= pend_reg.dlc;
            cs_reg[pend_idx_reg][TS_HI:0]         <= stamp_reg;
            // standard frames leave the low eighteen bits untouched
            if (pend_reg.ide) begin
               id_reg[pend_idx_reg][28:0]  <= pend_reg.id;
            end else begin
               id_reg[pend_idx_reg][28:18] <= pend_reg.id[28:18];
            end
            dlo_reg[pend_idx_reg] <= pend_reg.data[63:32];
            dhi_reg[pend_idx_reg] <= pend_reg.data[31:0];
         end
         // sent once: remote slots turn into receivers, data slots go idle
         if (tx_done && tx_valid_reg) begin
            cs_reg[tx_idx_reg][CODE_HI:CODE_LO] <=
               cs_reg[tx_idx_reg][RTR_POS] ? RX_EMPTY : TX_INACTIVE;
            cs_reg[tx_idx_reg][TS_HI:0] <= stamp_reg;
         end
      end
   end

   ////////////////////
   // transmit hand-out: frame built from the chosen slot on request
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         tx_valid_reg <= 1'b0;
         tx_idx_reg   <= '0;
         tx_frame_reg <= '0;
      end else begin
         if (tx_done) begin
            tx_valid_reg <= 1'b0;
         end else if (tx_fetch) begin
            tx_valid_reg <= tx_hit;
            tx_idx_reg   <= tx_pick;
            tx_frame_reg.ide  <= cs_reg[tx_pick][IDE_POS];
            tx_frame_reg.rtr  <= cs_reg[tx_pick][RTR_POS];
            tx_frame_reg.dlc  <= cs_reg[tx_pick][LEN_HI:LEN_LO];
            // remote frames carry no data whatever the length says
            tx_frame_reg.data_len <= cs_reg[tx_pick][RTR_POS] ? 4'h0 :
                                     cs_reg[tx_pick][LEN_HI:LEN_LO];
            tx_frame_reg.id   <= cs_reg[tx_pick][IDE_POS] ? id_reg[tx_pick][28:0]
                                 : (id_reg[tx_pick][28:0] & STD_MASK);
            tx_frame_reg.data <= {dlo_reg[tx_pick], dhi_reg[tx_pick]};
         end
      end
   end

   ////////////////////
   // remote bit monitor: a dominant read of a recessive bit is lost
   // arbitration, the opposite is a bit error
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         arb_lost_reg  <= 1'b0;
         bit_error_reg <= 1'b0;
      end else begin
         arb_lost_reg  <= rtr_check && rtr_sent && !rtr_seen;
         bit_error_reg <= rtr_check && !rtr_sent && rtr_seen;
      end
   end

   ////////////////////
   // completion flags: set wins over a write-one clear
   always_comb begin
      flag_set = '0;
      if (rx_state_reg == CMB_FILL) begin
         flag_set[pend_idx_reg] = 1'b1;
      end
      if (tx_done && tx_valid_reg) begin
         flag_set[tx_idx_reg] = 1'b1;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         flag_reg   <= '0;
         irq_en_reg <= '0;
         irq_reg    <= 1'b0;
      end else begin
         if (host_wr && host_addr == FLAG_OFS) begin
            flag_reg <= (flag_reg & ~host_wdata[SLOTS-1:0]) | flag_set;
         end else begin
            flag_reg <= flag_reg | flag_set;
         end
         if (host_wr && host_addr == IRQ_EN_OFS) begin
            irq_en_reg <= host_wdata[SLOTS-1:0];
         end
         // one cycle behind the flags so the output comes from a flop
         irq_reg <= |(flag_reg & irq_en_reg);
      end
   end

   ////////////////////
   // read data, one cycle after the strobe; unmapped reads give zero
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         rdata_reg <= '0;
      end else if (host_rd) begin
         if (in_slots(host_addr)) begin
            case (word_of(host_addr))
               CS_WORD:  rdata_reg <= cs_reg[slot_of(host_addr)];
               ID_WORD:  rdata_reg <= id_reg[slot_of(host_addr)];
               DLO_WORD: rdata_reg <= dlo_reg[slot_of(host_addr)];
               default:  rdata_reg <= dhi_reg[slot_of(host_addr)];
            endcase
         end else if (host_addr == TIMER_OFS) begin
            rdata_reg <= {16'h0000, timer_reg};
         end else if (host_addr == FLAG_OFS) begin
            rdata_reg <= 32'(flag_reg);
         end else if (host_addr == IRQ_EN_OFS) begin
            rdata_reg <= 32'(irq_en_reg);
         end else begin
            rdata_reg <= '0;
         end
      end else begin
         rdata_reg <= '0;
      end
   end

   ////////////////////
   // outputs
   assign host_rdata = rdata_reg;
   assign rx_ready   = rx_ready_reg;
   assign tx_valid   = tx_valid_reg;
   assign tx_frame   = tx_frame_reg;
   assign arb_lost   = arb_lost_reg;
   assign bit_error  = bit_error_reg;
   assign irq        = irq_reg;

endmodule : cmb_slots

/* testbench/cmb_slots_properties.sv */
// cmb_slots_properties: port timing checks for the message slot block.
// assumes one clock and a synchronous active low reset.
module cmb_slots_properties (
   input wire logic                   ref_clk,
   input wire logic                   rst_n,
   input wire logic                   host_rd,
   input wire logic [31:0]            host_rdata,
   input wire logic                   rx_valid,
   input wire logic                   rx_ready,
   input wire logic                   tx_valid,
   input wire logic                   tx_done,
   input wire cmb_pkg::cmb_tx_frame_t tx_frame,
   input wire logic                   rtr_check,
   input wire logic                   rtr_sent,
   input wire logic                   rtr_seen,
   input wire logic                   arb_lost,
   input wire logic                   bit_error
);
   timeunit 1ns;
   timeprecision 1ns;
   import cmb_pkg::*;
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (!rst_n);
   ////////////////////
   // remote bit monitor
   AST_ARB_LOST: assert property (rtr_check && rtr_sent && !rtr_seen |=> arb_lost && !bit_error)
      else $error("arbitration loss not flagged");
   AST_BIT_ERR: assert property (rtr_check && !rtr_sent && rtr_seen |=> bit_error && !arb_lost)
      else $error("bit error not flagged");
   AST_BIT_OK: assert property (rtr_check && (rtr_sent == rtr_seen) |=> !arb_lost && !bit_error)
      else $error("matching remote bit flagged");
   ////////////////////
   // a store keeps ready low at least two cycles; a dropped frame leaves it high
   AST_STORE_BUSY: assert property (rx_valid && rx_ready ##1 !rx_ready |=> !rx_ready)
      else $error("store sequence too short");
   AST_STORE_END: assert property ($fell(rx_ready) |-> ##[2:60] rx_ready)
      else $error("store sequence hung");
   // read data only in the cycle after a read strobe
   AST_RD_IDLE: assert property (!$past(host_rd) |-> host_rdata == 32'h0)
      else $error("read data outside answer cycle");
   ////////////////////
   // transmit hand-out
   AST_TX_HOLD: assert property (tx_valid && !tx_done |=> tx_valid && $stable(tx_frame))
      else $error("presented frame changed");
   AST_TX_LEN: assert property (tx_valid && !tx_frame.rtr |-> tx_frame.data_len == tx_frame.dlc)
      else $error("data length differs from dlc");
   AST_TX_REMOTE: assert property (tx_valid && tx_frame.rtr |-> tx_frame.data_len == 4'h0)
      else $error("remote frame carries data");
   AST_TX_STD: assert property (tx_valid && !tx_frame.ide |-> tx_frame.id[17:0] == 18'h0)
      else $error("standard id low bits sent");
   cover property (rx_valid && rx_ready);
   cover property (tx_valid && tx_done);
   cover property (arb_lost);
   cover property (bit_error);
endmodule : cmb_slots_properties
bind cmb_slots cmb_slots_properties chk (.ref_clk(ref_clk), .rst_n(rst_n),
   .host_rd(host_rd), .host_rdata(host_rdata), .rx_valid(rx_valid), .rx_ready(rx_ready),
   .tx_valid(tx_valid), .tx_done(tx_done), .tx_frame(tx_frame), .rtr_check(rtr_check),
   .rtr_sent(rtr_sent), .rtr_seen(rtr_seen), .arb_lost(arb_lost), .bit_error(bit_error));

/* testbench/cmb_engine_model.sv */
// cmb_engine_model: protocol engine stand-in on the far side of the slots.
// assumes its tasks are called from one bench process.
module cmb_engine_model (
   input  wire logic                   ref_clk,
   input  wire logic                   rx_ready,
   input  wire logic                   tx_valid,
   input  wire cmb_pkg::cmb_tx_frame_t tx_frame,
   output logic                        rx_valid,
   output cmb_pkg::cmb_frame_t         rx_frame,
   output logic                        id_start,
   output logic                        tx_fetch,
   output logic                        tx_done,
   output logic                        rtr_check,
   output logic                        rtr_sent,
   output logic                        rtr_seen
);
   timeunit 1ns;
   timeprecision 1ns;
   import cmb_pkg::*;
   initial begin
      {rx_valid, id_start, tx_fetch, tx_done, rtr_check, rtr_sent, rtr_seen} = '0;
      rx_frame = '0;
   end
   // id start, frame held until taken, then inverted
   task send(input cmb_frame_t f);
      @(posedge ref_clk);
      id_start <= 1'b1;
      @(posedge ref_clk);
      id_start <= 1'b0;
      rx_valid <= 1'b1;
      rx_frame <= f;
      do @(posedge ref_clk); while (rx_ready !== 1'b1);
      rx_valid <= 1'b0;
      rx_frame <= ~f;
   endtask : send
   // fetch, hold gap cycles, report sent
   task fetch(output cmb_tx_frame_t f, input int gap);
      @(posedge ref_clk);
      tx_fetch <= 1'b1;
      @(posedge ref_clk);
      tx_fetch <= 1'b0;
      @(posedge ref_clk);
      f = tx_frame;
      repeat (gap) @(posedge ref_clk);
      tx_done <= tx_valid;
      @(posedge ref_clk);
      tx_done <= 1'b0;
   endtask : fetch
   task rtr(input logic s, input logic e);
      @(posedge ref_clk);
      rtr_check <= 1'b1;
      rtr_sent <= s;
      rtr_seen <= e;
      @(posedge ref_clk);
      rtr_check <= 1'b0;
   endtask : rtr
endmodule : cmb_engine_model

/* testbench/tb_cmb_slots.sv */
// tb_cmb_slots: receive codes, transmit hand-out, remote bit and request.
// assumes the engine model drives the far side; the checker is bound.
module tb_cmb_slots;
   timeunit 1ns;
   timeprecision 1ns;
   import cmb_pkg::*;
   logic ref_clk = 0, rst_n = 0, host_wr = 0, host_rd = 0, rd_q = 0;
   logic [8:0] host_addr = '0;
   logic [31:0] host_wdata = '0, host_rdata, m, e;
   logic rx_valid, rx_ready, id_start, tx_fetch, tx_valid, tx_done, irq;
   logic rtr_check, rtr_sent, rtr_seen, arb_lost, bit_error;
   logic [28:0] a_id, b_id;
   cmb_frame_t rx_frame, f;
   cmb_tx_frame_t tx_frame, t, x;
   logic [63:0] exp_q[$];
   int miscompares = 0, samples_checked = 0, cycles = 0;
   cmb_slots uut (.ref_clk(ref_clk), .rst_n(rst_n), .host_addr(host_addr),
      .host_wdata(host_wdata), .host_wr(host_wr), .host_rd(host_rd), .host_rdata(host_rdata),
      .rx_valid(rx_valid), .rx_frame(rx_frame), .rx_ready(rx_ready), .id_start(id_start),
      .tx_fetch(tx_fetch), .tx_valid(tx_valid), .tx_frame(tx_frame), .tx_done(tx_done),
      .rtr_check(rtr_check), .rtr_sent(rtr_sent), .rtr_seen(rtr_seen),
      .arb_lost(arb_lost), .bit_error(bit_error), .irq(irq));
   cmb_engine_model eng (.ref_clk(ref_clk), .rx_ready(rx_ready), .tx_valid(tx_valid),
      .tx_frame(tx_frame), .rx_valid(rx_valid), .rx_frame(rx_frame), .id_start(id_start),
      .tx_fetch(tx_fetch), .tx_done(tx_done), .rtr_check(rtr_check), .rtr_sent(rtr_sent),
      .rtr_seen(rtr_seen));
   always #50 ref_clk = ~ref_clk;
   task summarize;
      if (miscompares == 0 && samples_checked > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask : summarize
   task check(input logic [127:0] got, input logic [127:0] want);
      samples_checked++;
      if (got !== want) begin
         miscompares++;
         $display("unexpected at %0t: got %h want %h", $time, got, want);
      end
   endtask : check
   // read answers against the oldest note
   always @(posedge ref_clk) begin
      rd_q <= host_rd;
      cycles <= cycles + 1;
      if (rd_q) begin
         {m, e} = exp_q.pop_front();
         check(host_rdata & m, e);
      end
      if (cycles == 20000) begin
         miscompares++;
         summarize();
      end
   end
   ////////////////////
   task wr(input logic [8:0] a, input logic [31:0] d);
      @(posedge ref_clk);
      host_addr <= a;
      host_wdata <= d;
      host_wr <= 1'b1;
      @(posedge ref_clk);
      host_wr <= 1'b0;
   endtask : wr
   task rd(input logic [8:0] a, input logic [31:0] k, input logic [31:0] d);
      @(posedge ref_clk);
      host_addr <= a;
      host_rd <= 1'b1;
      exp_q.push_back({k, d & k});
      @(posedge ref_clk);
      host_rd <= 1'b0;
   endtask : rd
   function automatic logic [8:0] sa(input int n, input int w);
      return SLOT_BASE + 9'(16 * n + 4 * w);
   endfunction : sa
   function automatic logic [31:0] cs(logic [3:0] c, logic i, logic r, logic [3:0] l);
      return {4'h0, c, 2'b00, i, r, l, 16'h0};
   endfunction : cs
   // one random frame; no access until the store is over
   task rx(input logic [28:0] id, input logic i);
      f = {id, i, 1'b0, 4'($urandom_range(8)), $urandom, $urandom};
      eng.send(f);
      repeat (4) @(posedge ref_clk);
   endtask : rx
   // read a slot whole, then unlock via timer
   task chk(input int n, input logic [3:0] c, input logic [28:0] id);
      rd(sa(n, 0), 32'h0F3F_0000, cs(c, f.ide, 1'b0, f.dlc));
      rd(sa(n, 1), '1, {3'h0, id});
      rd(sa(n, 2), '1, f.data[63:32]);
      rd(sa(n, 3), '1, f.data[31:0]);
      rd(TIMER_OFS, '0, '0);
   endtask : chk
   initial begin
      void'($urandom(34));
      repeat (5) @(posedge ref_clk);
      rst_n <= 1'b1;
      a_id = 29'($urandom) & STD_MASK;
      b_id = 29'($urandom);
      wr(IRQ_EN_OFS, 32'h0000_FFFF);
      wr(sa(0, 1), {3'h0, a_id});
      wr(sa(1, 1), {3'h0, a_id});
      wr(sa(2, 1), {3'h0, b_id});
      wr(sa(1, 0), cs(RX_EMPTY, 1'b0, 1'b0, 4'h0));
      wr(sa(2, 0), cs(RX_EMPTY, 1'b1, 1'b0, 4'h0));
      // low id bits of standard frames must not matter
      rx(a_id | 29'($urandom_range(18'h3FFFF)), 1'b0);
      rd(sa(0, 0), 32'h0F00_0000, 32'h0);
      rd(TIMER_OFS, '0, '0);
      rx(a_id | 29'($urandom_range(18'h3FFFF)), 1'b0);
      rx(a_id, 1'b0);
      chk(1, RX_OVERRUN, a_id);
      rx(a_id, 1'b0);
      chk(1, RX_FULL, a_id);
      rx(a_id, 1'b0);
      chk(1, RX_FULL, a_id);
      rx(b_id ^ 29'h1, 1'b1);
      rd(sa(2, 0), 32'h0F00_0000, {4'h0, RX_EMPTY, 24'h0});
      rd(TIMER_OFS, '0, '0);
      rx(b_id, 1'b1);
      chk(2, RX_FULL, b_id);
      #1 check(irq, 1'b1);
      wr(FLAG_OFS, 32'h0);
      repeat (2) @(posedge ref_clk);
      #1 check(irq, 1'b1);
      wr(FLAG_OFS, 32'h0000_FFFF);
      repeat (2) @(posedge ref_clk);
      #1 check(irq, 1'b0);
      // data then remote frame from slot 3
      for (int r = 0; r < 2; r++) begin
         x = {29'($urandom), 2'(r), 4'($urandom_range(8)), 4'h0, $urandom, $urandom};
         wr(sa(3, 1), {3'h0, x.id});
         wr(sa(3, 2), x.data[63:32]);
         wr(sa(3, 3), x.data[31:0]);
         wr(sa(3, 0), cs(TX_ONCE, 1'b0, x.rtr, x.dlc));
         x.id = x.id & STD_MASK;
         x.data_len = x.rtr ? 4'h0 : x.dlc;
         eng.fetch(t, 3 * r);
         check(t, x);
         repeat (2) @(posedge ref_clk);
         rd(sa(3, 0), 32'h0E3F_0000, cs(r ? RX_EMPTY : TX_INACTIVE, 1'b0, x.rtr, x.dlc));
         rd(TIMER_OFS, '0, '0);
      end
      for (int k = 0; k < 4; k++) begin
         eng.rtr(k[1], k[0]);
         #1 check({arb_lost, bit_error}, {k[1] & ~k[0], ~k[1] & k[0]});
      end
      repeat (3) @(posedge ref_clk);
      summarize();
   end
endmodule : tb_cmb_slots
